// File: bench/gain_routing_monitor.sv
// concurrent checks on the mixer register bank ports
`timescale 1ns/1ps
`default_nettype none
module gain_routing_monitor (
	input wire logic	clock,
	input wire logic	rst_n,
	input wire logic [7:0]	reg_addr,
	input wire logic	reg_write,
	input wire logic	reg_read,
	input wire logic [7:0]	reg_rdata,
	input wire logic	source_valid,
	input wire logic	source_ready,
	input wire logic	mix_valid,
	input wire logic	mix_ready,
	input wire logic [23:0]	serial_port_out_right,
	input wire logic [23:0]	dac_filter_feed_left
);
	logic		wrote;
	wire logic	gain_sel = reg_addr inside {[8'h68:8'h6b], [8'h6d:8'h70]};
	wire logic	mask_sel = reg_addr == 8'h64 || reg_addr == 8'h6c;
	// any write spoils the reset-value checks until the next reset
	always_ff @(posedge clock)
		if (!rst_n)
			wrote <= 1'b0;
		else if (reg_write)
			wrote <= 1'b1;
	default clocking dc @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_gain_reset:
	assert property (reg_read && !wrote && gain_sel |=> reg_rdata == 8'h1c)
		else $error("gain field not at reset value");
	a_left_mask_reset:
	assert property (reg_read && !wrote && reg_addr == 8'h6c
		|=> reg_rdata == 8'h01)
		else $error("left feed mask not at reset value");
	a_right_mask_reset:
	assert property (reg_read && !wrote && reg_addr == 8'h64
		|=> reg_rdata == 8'h04)
		else $error("right port mask not at reset value");
	a_gain_field_width:
	assert property (reg_read && gain_sel |=> reg_rdata[7:5] == 3'b000)
		else $error("gain register shows bits above the field");
	a_mask_bit_reserved:
	assert property (reg_read && mask_sel |=> !reg_rdata[7])
		else $error("mask register shows its reserved bit");
	a_hole_reads_zero:
	assert property (reg_read && !gain_sel && !mask_sel
		|=> reg_rdata == 8'h00)
		else $error("unmapped offset read not zero");
	a_pair_holds:
	assert property (mix_valid && !mix_ready |=> mix_valid
		&& $stable(serial_port_out_right) && $stable(dac_filter_feed_left))
		else $error("output pair changed before it was taken");
	a_take_once:
	assert property (source_valid && source_ready |=> !source_ready)
		else $error("input ready stayed high after a take");
	a_take_yields_out:
	assert property (source_valid && source_ready |-> ##[1:4] mix_valid)
		else $error("taken set produced no output");
	c_take: cover property (source_valid && source_ready);
	c_stall: cover property ((mix_valid && !mix_ready) [*2]);
	c_gain_read: cover property (reg_read && gain_sel ##1 1'b1);
endmodule
bind digital_mixer_gain_routing gain_routing_monitor u_mon (
	.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.source_valid(source_valid), .source_ready(source_ready),
	.mix_valid(mix_valid), .mix_ready(mix_ready),
	.serial_port_out_right(serial_port_out_right),
	.dac_filter_feed_left(dac_filter_feed_left)
);
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the mixer gain and routing bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic			clock, rst_n, reg_write, reg_read;
	logic			source_valid, source_ready, mix_valid, mix_ready;
	logic [7:0]		reg_addr, reg_wdata, reg_rdata;
	logic [6:0][23:0]	source_samples;
	logic [23:0]		serial_port_out_right, dac_filter_feed_left;
	logic [7:0]		sh [0:255];
	logic [47:0]		exp_q [$];
	logic [7:0]		rd_q [$];
	int			err_count, n_compared, seed, mode, cnt;
	bit			rd_seen, ok;
	wire logic [47:0]	out_pair = {serial_port_out_right, dac_filter_feed_left};

	digital_mixer_gain_routing dut (
		.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .source_samples(source_samples),
		.source_valid(source_valid), .source_ready(source_ready),
		.mix_valid(mix_valid), .mix_ready(mix_ready),
		.serial_port_out_right(serial_port_out_right),
		.dac_filter_feed_left(dac_filter_feed_left)
	);

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// writable bits per offset; holes keep none
	function automatic logic [7:0] fmask(input int a);
		if (a == 8'h64 || a == 8'h6c)
			return 8'h7f;
		return (a inside {[8'h68:8'h6b], [8'h6d:8'h70]}) ? 8'h1f : 8'h00;
	endfunction

	function automatic logic [7:0] rst_val(input int a);
		if (fmask(a) == 8'h1f)
			return 8'h1c;
		return (a == 8'h64) ? 8'h04 : (a == 8'h6c) ? 8'h01 : 8'h00;
	endfunction

	function automatic longint glin(input logic [4:0] c);
		return longint'($rtoi(16384.0 * 10.0 ** ((1.5 * c - 42.0) / 20.0) + 0.5));
	endfunction

	// each product is shifted alone, so tiny terms vanish before the sum
	function automatic logic [23:0] mixed(input bit left);
		longint		acc;
		logic [4:0]	g;
		acc = 0;
		for (int i = 0; i < 7; i++)
		begin
			g = 5'h1c;
			if (left && i < 4)
				g = sh[8'h6d + i][4:0];
			if (!left && i > 2)
				g = sh[8'h65 + i][4:0];
			if (sh[left ? 8'h6c : 8'h64][i])
				acc += (longint'($signed(source_samples[i])) * glin(g)) >>> 14;
		end
		if (acc > 64'sh7fffff)
			acc = 64'sh7fffff;
		if (acc < -64'sh800000)
			acc = -64'sh800000;
		return acc[23:0];
	endfunction

	task automatic check(input logic [47:0] got, input logic [47:0] want);
		n_compared++;
		if (got !== want)
		begin
			err_count++;
			$display("BAD t=%0t got=%h want=%h", $time, got, want);
		end
	endtask

	// strobes get an idle cycle so no task re-raises one in the same step
	task automatic wr(input int a, input logic [7:0] d);
		reg_addr = a[7:0];
		reg_wdata = d;
		reg_write = 1'b1;
		sh[a] = d & fmask(a);
		@(negedge clock);
		reg_write = 1'b0;
		@(negedge clock);
	endtask

	task automatic rd(input int a);
		reg_addr = a[7:0];
		reg_read = 1'b1;
		rd_q.push_back(sh[a]);
		@(negedge clock);
		reg_read = 1'b0;
		@(negedge clock);
	endtask

	task automatic push(input int lim);
		int	k;
		k = 0;
		for (int i = 0; i < 7; i++)
			source_samples[i] = 24'($random(seed));
		source_valid = 1'b1;
		while (source_ready !== 1'b1 && k < lim)
		begin
			@(negedge clock);
			k++;
		end
		ok = source_ready === 1'b1;
		// only the full-fifo probe uses a short limit and may be refused
		if (!ok && lim > 20)
			err_count++;
		if (ok)
		begin
			exp_q.push_back({mixed(1'b0), mixed(1'b1)});
			@(negedge clock);
		end
	endtask

	task automatic drain();
		int	k;
		source_valid = 1'b0;
		k = 0;
		while (exp_q.size() > 0 && k < 400)
		begin
			@(negedge clock);
			k++;
		end
		if (exp_q.size() > 0)
			err_count++;
		@(negedge clock);
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(negedge clock)
		mix_ready <= (mode == 2) || (mode == 1 && $random(seed) % 2 == 0);

	always @(posedge clock)
	begin
		if (rd_seen)
			check(reg_rdata, rd_q.pop_front());
		rd_seen = rst_n && reg_read;
		if (rst_n && mix_valid === 1'b1 && mix_ready === 1'b1)
			check(out_pair, exp_q.pop_front());
	end

	// the work needs about a thousand cycles; 40000 means a hang
	initial
	begin
		#200000;
		err_count++;
		summarize();
	end

	initial
	begin
		seed = 70526;
		err_count = 0;
		n_compared = 0;
		mode = 2;
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		source_valid = 1'b0;
		source_samples = '0;
		rd_seen = 1'b0;
		for (int a = 0; a < 256; a++)
			sh[a] = rst_val(a);
		repeat (3) @(negedge clock);
		rst_n = 1'b1;
		for (int a = 8'h60; a < 8'h73; a++)
			rd(a);
		for (int a = 8'h60; a < 8'h73; a++)
		begin
			wr(a, 8'($random(seed)));
			rd(a);
		end
		wr(8'h6c, 8'h01);
		for (int c = 0; c < 32; c++)
		begin
			wr(8'h6d, c[7:0]);
			push(50);
			drain();
		end
		// reserved mask bit set on purpose: it must not route anything
		for (int b = 0; b < 7; b++)
		begin
			wr(8'h64, 8'h01 << b);
			wr(8'h6c, 8'h80 | (8'h01 << b));
			push(50);
			drain();
		end
		mode = 1;
		repeat (12)
		begin
			for (int a = 8'h64; a < 8'h71; a++)
				wr(a, 8'($random(seed)));
			repeat (4) push(50);
			drain();
		end
		mode = 0;
		cnt = 0;
		ok = 1'b1;
		while (ok && cnt < 40)
		begin
			push(20);
			cnt += ok;
		end
		check(cnt, 34);
		mode = 1;
		while (!ok) push(50);
		drain();
		check(exp_q.size(), 0);
		summarize();
	end
endmodule
`default_nettype wire

// File: common/mixer_pkg.sv
// constants shared by the mixer register bank and its sample fifo
package mixer_pkg;
	localparam int SAMPLE_W = 24;
	localparam int PAIR_W = 48;
	localparam int FIFO_DEPTH = 32;
	localparam int NUM_SRC = 7;
	localparam int GAIN_W = 5;
	localparam int GAIN_LIN_W = 16;
	localparam int GAIN_FRAC = 14;
	localparam int ACC_W = 29;

	// register offsets
	localparam logic [7:0] OFS_PORT_OUT_R_SRC = 8'h64;
	localparam logic [7:0] OFS_PORTO_R_FROM_FILT2_R_GAIN = 8'h68;
	localparam logic [7:0] OFS_PORTO_R_FROM_TONE_GAIN = 8'h69;
	localparam logic [7:0] OFS_PORTO_R_FROM_PORTI_L_GAIN = 8'h6a;
	localparam logic [7:0] OFS_PORTO_R_FROM_PORTI_R_GAIN = 8'h6b;
	localparam logic [7:0] OFS_DACF_L_SOURCE_SELECT = 8'h6c;
	localparam logic [7:0] OFS_DACF_L_FROM_FILT1_L_GAIN = 8'h6d;
	localparam logic [7:0] OFS_DACF_L_FROM_FILT1_R_GAIN = 8'h6e;
	localparam logic [7:0] OFS_DACF_L_FROM_FILT2_L_GAIN = 8'h6f;
	localparam logic [7:0] OFS_DACF_L_FROM_FILT2_R_GAIN = 8'h70;

	// field layout
	localparam int GAIN_LSB = 0;
	localparam int GAIN_MSB = 4;
	localparam int MASK_LSB = 0;
	localparam int MASK_MSB = 6;

	// reset values and the unity gain code
	localparam logic [4:0] GAIN_RESET = 5'h1c;
	localparam logic [6:0] DAC_FEED_LEFT_MASK_RESET = 7'h01;
	localparam logic [6:0] PORT_OUT_RIGHT_MASK_RESET = 7'h04;
	localparam logic [4:0] GAIN_UNITY_CODE = 5'h1c;

	// source bit positions in a routing mask
	localparam int SRC_FILT1_L = 0;
	localparam int SRC_FILT1_R = 1;
	localparam int SRC_FILT2_L = 2;
	localparam int SRC_FILT2_R = 3;
	localparam int SRC_TONE = 4;
	localparam int SRC_PORTI_L = 5;
	localparam int SRC_PORTI_R = 6;
endpackage

// File: common/sample_stream_if.sv
// valid/ready stream carrier between the mixer and its fifo
`timescale 1ns/1ps
`default_nettype none
interface sample_stream_if #(parameter int WIDTH = 48);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: design/digital_mixer_gain_routing.sv
// mixer gain and routing registers with the two mixed outputs on one valid/ready stream
`timescale 1ns/1ps
`default_nettype none

module digital_mixer_gain_routing (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_write,
	input  wire logic                  reg_read,
	output logic      [7:0]            reg_rdata,
	input  wire logic [6:0][23:0]      source_samples,
	input  wire logic                  source_valid,
	output logic                       source_ready,
	output logic                       mix_valid,
	output logic      [23:0]           serial_port_out_right,
	output logic      [23:0]           dac_filter_feed_left,
	input  wire logic                  mix_ready
);
	localparam int SW = mixer_pkg::SAMPLE_W;
	localparam int AW = mixer_pkg::ACC_W;
	localparam int GW = mixer_pkg::GAIN_W;

	// 1.5 dB steps as linear gain, 2.14 fixed point
	function automatic logic [15:0] gain_lut(input logic [4:0] code);
		logic [15:0] g;
		g = 16'h0000;
		case (code)
			5'h00: g = 16'h0082;
			5'h01: g = 16'h009b;
			5'h02: g = 16'h00b8;
			5'h03: g = 16'h00da;
			5'h04: g = 16'h0104;
			5'h05: g = 16'h0135;
			5'h06: g = 16'h016f;
			5'h07: g = 16'h01b4;
			5'h08: g = 16'h0206;
			5'h09: g = 16'h0268;
			5'h0a: g = 16'h02dc;
			5'h0b: g = 16'h0366;
			5'h0c: g = 16'h040a;
			5'h0d: g = 16'h04cd;
			5'h0e: g = 16'h05b4;
			5'h0f: g = 16'h06c7;
			5'h10: g = 16'h080f;
			5'h11: g = 16'h0993;
			5'h12: g = 16'h0b62;
			5'h13: g = 16'h0d87;
			5'h14: g = 16'h1013;
			5'h15: g = 16'h131b;
			5'h16: g = 16'h16b5;
			5'h17: g = 16'h1afd;
			5'h18: g = 16'h2013;
			5'h19: g = 16'h261f;
			5'h1a: g = 16'h2d4f;
			5'h1b: g = 16'h35d9;
			5'h1c: g = 16'h4000;
			5'h1d: g = 16'h4c10;
			5'h1e: g = 16'h5a67;
			5'h1f: g = 16'h6b72;
			default: g = 16'h4000;
		endcase
		return g;
	endfunction

	// weighted sum over the sources that the mask selects
	function automatic logic signed [28:0] mix(
		input logic [6:0][23:0] s,
		input logic [6:0]       m,
		input logic [6:0][4:0]  g
	);
		logic signed [28:0] acc;
		logic signed [40:0] p;
		acc = '0;
		p = '0;
		for (int i = 0; i < mixer_pkg::NUM_SRC; i++)
		begin
			p = $signed(s[i]) * $signed({1'b0, gain_lut(g[i])});
			if (m[i])
				acc = acc + 29'(p >>> mixer_pkg::GAIN_FRAC);
		end
		return acc;
	endfunction

	// clip the wide sum back into a sample word
	function automatic logic [23:0] clip(input logic signed [28:0] a);
		logic signed [28:0] hi;
		logic signed [28:0] lo;
		hi = 29'sh07fffff;
		lo = -29'sh0800000;
		if (a > hi)
			return 24'h7fffff;
		else if (a < lo)
			return 24'h800000;
		else
			return a[23:0];
	endfunction

	// register state
	logic [4:0] porto_r_from_filt2_r_gain;
	logic [4:0] porto_r_from_tone_gain;
	logic [4:0] porto_r_from_porti_l_gain;
	logic [4:0] porto_r_from_porti_r_gain;
	logic [6:0] port_out_right_source_mask;
	logic [6:0] dac_feed_left_source_mask;
	logic [4:0] dacf_l_from_filt1_l_gain;
	logic [4:0] dacf_l_from_filt1_r_gain;
	logic [4:0] dacf_l_from_filt2_l_gain;
	logic [4:0] dacf_l_from_filt2_r_gain;

	// address decode
	wire hit_mask_r = reg_addr == mixer_pkg::OFS_PORT_OUT_R_SRC;
	wire hit_r_f2r = reg_addr == mixer_pkg::OFS_PORTO_R_FROM_FILT2_R_GAIN;
	wire hit_r_tone = reg_addr == mixer_pkg::OFS_PORTO_R_FROM_TONE_GAIN;
	wire hit_r_pil = reg_addr == mixer_pkg::OFS_PORTO_R_FROM_PORTI_L_GAIN;
	wire hit_r_pir = reg_addr == mixer_pkg::OFS_PORTO_R_FROM_PORTI_R_GAIN;
	wire hit_mask_l = reg_addr == mixer_pkg::OFS_DACF_L_SOURCE_SELECT;
	wire hit_l_f1l = reg_addr == mixer_pkg::OFS_DACF_L_FROM_FILT1_L_GAIN;
	wire hit_l_f1r = reg_addr == mixer_pkg::OFS_DACF_L_FROM_FILT1_R_GAIN;
	wire hit_l_f2l = reg_addr == mixer_pkg::OFS_DACF_L_FROM_FILT2_L_GAIN;
	wire hit_l_f2r = reg_addr == mixer_pkg::OFS_DACF_L_FROM_FILT2_R_GAIN;

	wire [4:0] wgain = reg_wdata[mixer_pkg::GAIN_MSB:mixer_pkg::GAIN_LSB];
	wire [6:0] wmask = reg_wdata[mixer_pkg::MASK_MSB:mixer_pkg::MASK_LSB];

	// read mux; reserved bits and unmapped offsets read as zero
	wire [7:0] read_value =
		hit_mask_r ? {1'b0, port_out_right_source_mask} :
		hit_r_f2r  ? {3'h0, porto_r_from_filt2_r_gain} :
		hit_r_tone ? {3'h0, porto_r_from_tone_gain} :
		hit_r_pil  ? {3'h0, porto_r_from_porti_l_gain} :
		hit_r_pir  ? {3'h0, porto_r_from_porti_r_gain} :
		hit_mask_l ? {1'b0, dac_feed_left_source_mask} :
		hit_l_f1l  ? {3'h0, dacf_l_from_filt1_l_gain} :
		hit_l_f1r  ? {3'h0, dacf_l_from_filt1_r_gain} :
		hit_l_f2l  ? {3'h0, dacf_l_from_filt2_l_gain} :
		hit_l_f2r  ? {3'h0, dacf_l_from_filt2_r_gain} : 8'h00;

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			porto_r_from_filt2_r_gain <= mixer_pkg::GAIN_RESET;
			porto_r_from_tone_gain <= mixer_pkg::GAIN_RESET;
			porto_r_from_porti_l_gain <= mixer_pkg::GAIN_RESET;
			porto_r_from_porti_r_gain <= mixer_pkg::GAIN_RESET;
			dacf_l_from_filt1_l_gain <= mixer_pkg::GAIN_RESET;
			dacf_l_from_filt1_r_gain <= mixer_pkg::GAIN_RESET;
			dacf_l_from_filt2_l_gain <= mixer_pkg::GAIN_RESET;
			dacf_l_from_filt2_r_gain <= mixer_pkg::GAIN_RESET;
			port_out_right_source_mask <=
				mixer_pkg::PORT_OUT_RIGHT_MASK_RESET;
			dac_feed_left_source_mask <=
				mixer_pkg::DAC_FEED_LEFT_MASK_RESET;
		end
		else if (reg_write)
		begin
			if (hit_r_f2r)
				porto_r_from_filt2_r_gain <= wgain;
			if (hit_r_tone)
				porto_r_from_tone_gain <= wgain;
			if (hit_r_pil)
				porto_r_from_porti_l_gain <= wgain;
			if (hit_r_pir)
				porto_r_from_porti_r_gain <= wgain;
			if (hit_l_f1l)
				dacf_l_from_filt1_l_gain <= wgain;
			if (hit_l_f1r)
				dacf_l_from_filt1_r_gain <= wgain;
			if (hit_l_f2l)
				dacf_l_from_filt2_l_gain <= wgain;
			if (hit_l_f2r)
				dacf_l_from_filt2_r_gain <= wgain;
			if (hit_mask_r)
				port_out_right_source_mask <= wmask;
			if (hit_mask_l)
				dac_feed_left_source_mask <= wmask;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_read)
			reg_rdata <= read_value;
	end

	// per-source gain codes; paths held in other banks run at unity
	wire [6:0][4:0] gains_right = {
		porto_r_from_porti_r_gain,
		porto_r_from_porti_l_gain,
		porto_r_from_tone_gain,
		porto_r_from_filt2_r_gain,
		mixer_pkg::GAIN_UNITY_CODE,
		mixer_pkg::GAIN_UNITY_CODE,
		mixer_pkg::GAIN_UNITY_CODE
	};
	wire [6:0][4:0] gains_left = {
		mixer_pkg::GAIN_UNITY_CODE,
		mixer_pkg::GAIN_UNITY_CODE,
		mixer_pkg::GAIN_UNITY_CODE,
		dacf_l_from_filt2_r_gain,
		dacf_l_from_filt2_l_gain,
		dacf_l_from_filt1_r_gain,
		dacf_l_from_filt1_l_gain
	};

	wire signed [AW-1:0] sum_right =
		mix(source_samples, port_out_right_source_mask, gains_right);
	wire signed [AW-1:0] sum_left =
		mix(source_samples, dac_feed_left_source_mask, gains_left);

	// one sample set in flight; halves throughput but keeps timing simple
	logic          result_valid;
	logic [47:0]   result_pair;

	sample_stream_if #(.WIDTH(mixer_pkg::PAIR_W)) fifo_in ();
	sample_stream_if #(.WIDTH(mixer_pkg::PAIR_W)) fifo_out ();

	assign fifo_in.valid = result_valid;
	assign fifo_in.data = result_pair;

	wire take_in = source_valid && source_ready;
	wire push_out = result_valid && fifo_in.ready;
	wire load_out = !mix_valid || mix_ready;
	assign fifo_out.ready = load_out;

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			result_valid <= 1'b0;
			result_pair <= '0;
			source_ready <= 1'b0;
		end
		else
		begin
			if (take_in)
			begin
				result_valid <= 1'b1;
				result_pair <= {clip(sum_right), clip(sum_left)};
				source_ready <= 1'b0;
			end
			else if (push_out)
			begin
				result_valid <= 1'b0;
				source_ready <= 1'b1;
			end
			else if (!result_valid)
				source_ready <= 1'b1;
		end
	end

	sample_fifo #(
		.WIDTH(mixer_pkg::PAIR_W),
		.DEPTH(mixer_pkg::FIFO_DEPTH)
	) pair_fifo (
		.clock (clock),
		.rst_n (rst_n),
		.wr    (fifo_in),
		.rd    (fifo_out)
	);

	// output register so the stream ports come straight from flops
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			mix_valid <= 1'b0;
			serial_port_out_right <= '0;
			dac_filter_feed_left <= '0;
		end
		else if (load_out)
		begin
			mix_valid <= fifo_out.valid;
			if (fifo_out.valid)
			begin
				serial_port_out_right <= fifo_out.data[47:SW];
				dac_filter_feed_left <= fifo_out.data[SW-1:0];
			end
		end
	end
endmodule
`default_nettype wire

// File: design/README_unused.sv
// spare source file; it holds no code
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: design/sample_fifo.sv
// synchronous fifo holding mixed sample pairs
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 32
) (
	input  wire logic      clock,
	input  wire logic      rst_n,
	sample_stream_if.sink   wr,
	sample_stream_if.source rd
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	wire              push;
	wire              pop;

	assign wr.ready = (count != (PW+1)'(DEPTH));
	assign rd.valid = (count != '0);
	assign rd.data = mem[rd_ptr];
	assign push = wr.valid && wr.ready;
	assign pop = rd.valid && rd.ready;

	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_ptr] <= wr.data;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule
`default_nettype wire
